// File: dsc_pkg.sv
// Constants for the system control word and the coprocessor latch
package dsc_pkg;
   // Control word field positions
   localparam int BIT_FLAG     = 0;   // Four pending flags
   localparam int BIT_MASK     = 4;   // Four enable masks
   localparam int BIT_P1_CTRL  = 8;   // Port 1 reaches upper half
   localparam int BIT_EXT_FRM  = 9;   // External framing
   localparam int BIT_XF       = 10;  // External flag latch
   localparam int BIT_SER_EN   = 11;  // Serial companding mode
   localparam int BIT_ENC      = 12;  // Encoder enable
   localparam int BIT_DEC      = 13;  // Decoder enable
   localparam int BIT_ALAW     = 14;  // Law select
   localparam int BIT_SCLK_IN  = 15;  // Bit clock pin is input
   localparam int BIT_CNT      = 16;  // Frame count modulus, 8 bits
   localparam int BIT_PRE      = 24;  // Prescale code, 4 bits
   localparam int BIT_FR_WIDE  = 28;  // Frame pulse width
   localparam int BIT_TWOS     = 29;  // Twos-complement format
   localparam int BIT_WIDE     = 30;  // 16-bit latch
   localparam logic [31:0] CR_RESET = 32'h0000_0000;
   // Processor I/O port numbers
   localparam logic [2:0] PORT_CTRL_LO = 3'h0;
   localparam logic [2:0] PORT_CTRL_HI = 3'h1;
   localparam logic [2:0] PORT_COPROC  = 3'h5;
   // Frame pulse widths in bit clocks, and modulus offset
   localparam logic [3:0] FR_NARROW  = 4'h1;
   localparam logic [3:0] FR_WIDE    = 4'h8;
   localparam logic [8:0] CNT_OFFSET = 9'h002;
   // Synchronised pin vector layout
   localparam int PIN_WR = 0, PIN_RD = 1, PIN_BYTE = 2, PIN_EXTERNAL_INTERRUPT_PIN = 3;
   localparam int PIN_FSR = 4, PIN_FSX = 5, PIN_SCLK = 6, PIN_PM = 7;
   localparam int PIN_MC = 8, PIN_DATA = 9, NPIN = 25;
   // Master clock divide ratio for a prescale code
   function automatic logic [5:0] pre_ratio(input logic [3:0] code);
      case (code)
         4'h1:    pre_ratio = 6'h1C;  // 28
         4'h2:    pre_ratio = 6'h18;  // 24
         4'h4:    pre_ratio = 6'h14;  // 20
         4'h8:    pre_ratio = 6'h10;  // 16
         4'h9:    pre_ratio = 6'h0E;  // 14
         4'hA:    pre_ratio = 6'h0C;  // 12
         4'hC:    pre_ratio = 6'h0A;  // 10
         default: pre_ratio = 6'h20;  // 32, also for undefined codes
      endcase
   endfunction
endpackage

// File: dsc_sys_ctrl.sv
// System control word, bit clock and frame timing, and host latch with FIFO
module dsc_fifo
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
)
(
   input  wire logic             clk,
   input  wire logic             rstN,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);
   // Pointers wrap by overflow, so DEPTH must be a power of two
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;  // Storage words
      logic [AW-1:0]               wr;   // Write pointer
      logic [AW-1:0]               rd;   // Read pointer
      logic [AW:0]                 cnt;  // Fill level
   } dsc_fifo_state_type;
   dsc_fifo_state_type q, d;
   logic push, pop;

   // Honest full and empty straight from the fill level
   assign inReady  = (q.cnt != (AW+1)'(DEPTH));
   assign outValid = (q.cnt != '0);
   assign outData  = q.mem[q.rd];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   // Next state
   always_comb
   begin
      d = q;
      if (push)
      begin
         d.mem[q.wr] = inData;
         d.wr        = q.wr + 1'b1;
      end
      if (pop)
         d.rd = q.rd + 1'b1;
      case ({push, pop})
         2'b10:   d.cnt = q.cnt + 1'b1;
         2'b01:   d.cnt = q.cnt - 1'b1;
         default: d.cnt = q.cnt;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
         q <= '0;
      else
         q <= d;
   end
endmodule

module dsc_sys_ctrl
(
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic [2:0]  ioAddr,
   input  wire logic        ioWrStb,
   input  wire logic        ioRdStb,
   input  wire logic [15:0] ioWrData,
   output logic [15:0]      ioRdData,
   output logic             cpuIrq,
   input  wire logic        coprocessorModeSelect,
   input  wire logic        microcomputerSelectPin,
   input  wire logic        hostWrN,
   input  wire logic        hostRdN,
   input  wire logic        latchByteSelect,
   input  wire logic [15:0] hostDataIn,
   output logic [15:0]      hostDataOut,
   output logic             hostDataOe,
   output logic             hostWrReady,
   output logic             receiveLatchEmptyFlag,
   output logic             transmitLatchFullFlag,
   output logic             transferDonePollInput,
   input  wire logic        externalInterruptPin,
   input  wire logic        receiveFrameSyncIn,
   input  wire logic        transmitFrameSyncIn,
   input  wire logic        serialClockIn,
   output logic             serialClockOut,
   output logic             serialClockOe,
   output logic             internalFramePulse,
   output logic             txFrameStart,
   output logic             rxFrameStart,
   output logic             serialEnable,
   output logic             encoderEnable,
   output logic             decoderEnable,
   output logic             aLawSelect,
   output logic             twosComplementSelect,
   output logic             externalFlagOutput,
   output logic             compWrStrobe,
   output logic [15:0]      compWrData,
   input  wire logic [15:0] compRdData
);
   localparam int NP = dsc_pkg::NPIN;
   typedef struct packed {
      logic [NP-1:0] s1, s2, s3, flt;  // Pin synchronisers and filter
      logic [31:0]   cr;               // System control word
      logic [5:0]    preCnt;           // Prescaler phase
      logic          sclk;             // Generated bit clock
      logic [8:0]    frCnt;            // Frame counter
      logic [3:0]    frLeft;           // Bit clocks of pulse left
      logic          frPulse;          // Internal frame pulse
      logic          txStart, rxStart; // Framing strobes
      logic [7:0]    hiByte;           // High byte held in byte mode
      logic [15:0]   txLatch;          // Processor to host latch
      logic          transmit_latch_full_flag, done, receive_latch_empty_flag; // Handshake flags
      logic          latchRead;        // Latch read seen in the last cycle
      logic [15:0]   hostOut;          // Host read data
      logic          hostOe;           // Host data drive
      logic [15:0]   rdData;           // Processor read data
      logic          irq;              // Interrupt request
      logic          compWr;           // Port 1 write to companding
      logic [15:0]   compData;         // Its data
   } dsc_state_type;
   dsc_state_type q, d;
   logic [1:0]    rstPipe;  // Reset release synchroniser
   logic          rstN;     // Synchronised reset
   logic [NP-1:0] fltNext;  // Filtered pins, next value
   logic [NP-1:0] pinsIn;
   logic          coproc, wrFall, wrRise, rdFall, rdRise, tick, frStart;
   logic          p0Wr, p1Wr, p5Wr, p5Rd;
   logic [3:0]    ev, clr;
   logic          fifoInValid, fifoInReady, fifoOutValid, fifoPop;
   logic [15:0]   fifoInData, fifoOutData;
   logic [5:0]    ratio;

   // Reset is released through two flip-flops
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         rstPipe <= 2'h0;
      else
         rstPipe <= {rstPipe[0], 1'b1};
   end
   assign rstN = rstPipe[1];

   assign pinsIn = {hostDataIn, microcomputerSelectPin, coprocessorModeSelect, serialClockIn,
                    transmitFrameSyncIn, receiveFrameSyncIn, externalInterruptPin,
                    latchByteSelect, hostRdN, hostWrN};

   // A pin change is accepted once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi++)
      begin : g_flt
         assign fltNext[gi] = (q.s2[gi] == q.s3[gi]) ? q.s3[gi] : q.flt[gi];
      end
   endgenerate

   // Edge events of the filtered host strobes and sources
   assign wrFall = q.flt[dsc_pkg::PIN_WR] & ~fltNext[dsc_pkg::PIN_WR];
   assign wrRise = ~q.flt[dsc_pkg::PIN_WR] & fltNext[dsc_pkg::PIN_WR];
   assign rdFall = q.flt[dsc_pkg::PIN_RD] & ~fltNext[dsc_pkg::PIN_RD];
   assign rdRise = ~q.flt[dsc_pkg::PIN_RD] & fltNext[dsc_pkg::PIN_RD];
   // Both mode pins low is the latch mode; mismatched pins fall to generic I/O
   assign coproc = ~q.flt[dsc_pkg::PIN_PM] & ~q.flt[dsc_pkg::PIN_MC];

   // Processor port decode
   assign p0Wr = ioWrStb && (ioAddr == dsc_pkg::PORT_CTRL_LO);
   assign p1Wr = ioWrStb && (ioAddr == dsc_pkg::PORT_CTRL_HI);
   assign p5Wr = ioWrStb && (ioAddr == dsc_pkg::PORT_COPROC) && coproc;
   assign p5Rd = ioRdStb && (ioAddr == dsc_pkg::PORT_COPROC) && coproc;
   assign fifoPop = p5Rd;

   assign ratio = dsc_pkg::pre_ratio(q.cr[dsc_pkg::BIT_PRE +: 4]);
   // Bit tick: generated clock wrap or a filtered rise on the pin
   assign tick = q.cr[dsc_pkg::BIT_SCLK_IN]
               ? (~q.flt[dsc_pkg::PIN_SCLK] & fltNext[dsc_pkg::PIN_SCLK])
               : (q.preCnt == ratio - 6'h01);
   assign frStart = tick && (q.frCnt >= {1'b0, q.cr[dsc_pkg::BIT_CNT +: 8]} + 9'h001);

   // Host word into the FIFO; byte mode takes the high half first
   always_comb
   begin
      fifoInValid = 1'b0;
      // Never the raw pins: they are not yet synchronised here
      fifoInData  = 16'h0000;
      if (q.cr[dsc_pkg::BIT_WIDE])
      begin
         fifoInValid = coproc & wrRise;
         fifoInData  = fltNext[dsc_pkg::PIN_DATA +: 16];
      end
      else
      begin
         fifoInValid = coproc & wrRise & ~q.flt[dsc_pkg::PIN_BYTE];
         fifoInData  = {q.hiByte, fltNext[dsc_pkg::PIN_DATA +: 8]};
      end
   end

   dsc_fifo #(.WIDTH(16), .DEPTH(4)) u_rx_fifo
   (
      .clk      (core_clk),
      .rstN     (rstN),
      .inValid  (fifoInValid),
      .inReady  (fifoInReady),
      .inData   (fifoInData),
      .outValid (fifoOutValid),
      .outReady (fifoPop),
      .outData  (fifoOutData)
   );

   // Interrupt sources; in latch mode the host write replaces the pin
   assign ev[0] = coproc ? (wrRise & fifoInReady)
                : (~q.flt[dsc_pkg::PIN_EXTERNAL_INTERRUPT_PIN] & fltNext[dsc_pkg::PIN_EXTERNAL_INTERRUPT_PIN]);
   assign ev[1] = ~q.flt[dsc_pkg::PIN_FSR] & fltNext[dsc_pkg::PIN_FSR];
   assign ev[2] = ~q.flt[dsc_pkg::PIN_FSX] & fltNext[dsc_pkg::PIN_FSX];
   assign ev[3] = frStart;
   // Write one clears, zero leaves alone; latch read clears flag 0
   assign clr = (p0Wr ? ioWrData[3:0] : 4'h0) | {3'h0, p5Rd};

   // Next state of the whole block
   always_comb
   begin
      d     = q;
      d.s1  = pinsIn;
      d.s2  = q.s1;
      d.s3  = q.s2;
      d.flt = fltNext;
      // Flags: set wins over clear, and masks do not stop setting
      d.cr[3:0] = (q.cr[3:0] & ~clr) | ev;
      if (p0Wr)
         d.cr[15:4] = ioWrData[15:4];
      d.compWr = 1'b0;
      if (p1Wr && q.cr[dsc_pkg::BIT_P1_CTRL])
         d.cr[31:16] = {1'b0, ioWrData[14:0]};
      else if (p1Wr)
      begin
         d.compWr   = 1'b1;
         d.compData = ioWrData;
      end
      // Prescaler: high for the first half of each ratio
      if (tick || q.cr[dsc_pkg::BIT_SCLK_IN])
         d.preCnt = 6'h00;
      else
         d.preCnt = q.preCnt + 6'h01;
      d.sclk = (d.preCnt < {1'b0, ratio[5:1]});
      // Frame counter runs modulus plus two bit ticks per pulse
      if (frStart)
      begin
         d.frCnt  = 9'h000;
         d.frLeft = q.cr[dsc_pkg::BIT_FR_WIDE] ? dsc_pkg::FR_WIDE : dsc_pkg::FR_NARROW;
      end
      else if (tick)
      begin
         d.frCnt = q.frCnt + 9'h001;
         if (q.frLeft != 4'h0)
            d.frLeft = q.frLeft - 4'h1;
      end
      d.frPulse = (d.frLeft != 4'h0);
      // Serial transfers follow internal pulse or external syncs
      d.txStart = q.cr[dsc_pkg::BIT_EXT_FRM] ? ev[2] : frStart;
      d.rxStart = q.cr[dsc_pkg::BIT_EXT_FRM] ? ev[1] : frStart;
      // Byte mode: a high-half write is held until the low half
      if (coproc && wrRise && q.flt[dsc_pkg::PIN_BYTE] && !q.cr[dsc_pkg::BIT_WIDE])
         d.hiByte = fltNext[dsc_pkg::PIN_DATA +: 8];
      // Empty flag: host write start clears; set only once a read has left
      // the FIFO empty, so the host sees empty while words remain only when that read falls inside a host write
      d.latchRead = p5Rd;
      if (coproc && wrFall)
         d.receive_latch_empty_flag = 1'b0;
      else if (q.latchRead && !fifoOutValid && !fifoInValid)
         d.receive_latch_empty_flag = 1'b1;
      // Output latch: read start clears full, read end signals done
      if (rdFall)
      begin
         d.transmit_latch_full_flag   = 1'b0;
         d.hostOe = coproc;
      end
      if (rdRise)
      begin
         d.hostOe = 1'b0;
         d.done   = 1'b1;
      end
      else if (p5Wr)
         d.done = 1'b0;
      if (p5Wr)
      begin
         d.txLatch = ioWrData;
         d.transmit_latch_full_flag    = 1'b1;
      end
      if (q.cr[dsc_pkg::BIT_WIDE])
         d.hostOut = q.txLatch;
      else
         d.hostOut = {8'h00, q.flt[dsc_pkg::PIN_BYTE] ? q.txLatch[15:8] : q.txLatch[7:0]};
      // Read answer appears the cycle after the strobe
      if (ioAddr == dsc_pkg::PORT_CTRL_LO)
         d.rdData = q.cr[15:0];
      else if (ioAddr == dsc_pkg::PORT_CTRL_HI && q.cr[dsc_pkg::BIT_P1_CTRL])
         d.rdData = q.cr[31:16];
      else if (ioAddr == dsc_pkg::PORT_CTRL_HI)
         d.rdData = compRdData;
      else if (ioAddr == dsc_pkg::PORT_COPROC && coproc && fifoOutValid)
         d.rdData = fifoOutData;
      else
         d.rdData = 16'h0000;
      if (!ioRdStb)
         d.rdData = q.rdData;
      // Request stays up while any enabled flag is pending
      d.irq = |(q.cr[3:0] & q.cr[7:4]);
   end

   // State register; the control word resets to sign-magnitude
   always_ff @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         q      <= '0;
         q.cr   <= dsc_pkg::CR_RESET;
         q.receive_latch_empty_flag <= 1'b1;
         q.s1   <= {{16{1'b0}}, 9'h1C3};
         q.s2   <= {{16{1'b0}}, 9'h1C3};
         q.s3   <= {{16{1'b0}}, 9'h1C3};
         q.flt  <= {{16{1'b0}}, 9'h1C3};
      end
      else
         q <= d;
   end

   // Outputs
   assign ioRdData              = q.rdData;
   assign cpuIrq                = q.irq;
   assign hostDataOut           = q.hostOut;
   assign hostDataOe            = q.hostOe;
   assign hostWrReady           = fifoInReady;
   assign receiveLatchEmptyFlag = q.receive_latch_empty_flag;
   assign transmitLatchFullFlag = q.transmit_latch_full_flag;
   assign transferDonePollInput = q.done;
   assign serialClockOut        = q.sclk;
   assign serialClockOe         = ~q.cr[dsc_pkg::BIT_SCLK_IN];
   assign internalFramePulse    = q.frPulse;
   assign txFrameStart          = q.txStart;
   assign rxFrameStart          = q.rxStart;
   assign serialEnable          = q.cr[dsc_pkg::BIT_SER_EN];
   assign encoderEnable         = q.cr[dsc_pkg::BIT_ENC];
   assign decoderEnable         = q.cr[dsc_pkg::BIT_DEC];
   assign aLawSelect            = q.cr[dsc_pkg::BIT_ALAW];
   assign twosComplementSelect  = q.cr[dsc_pkg::BIT_TWOS];
   assign externalFlagOutput    = q.cr[dsc_pkg::BIT_XF];
   assign compWrStrobe          = q.compWr;
   assign compWrData            = q.compData;

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstN);
   logic [3:0] pulseTicks;  // Bit ticks seen while the pulse is high
   always_ff @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
         pulseTicks <= 4'h0;
      else if (frStart)
         pulseTicks <= 4'h0;
      else if (tick && q.frPulse)
         pulseTicks <= pulseTicks + 4'h1;
   end
   sequence sHostWrite;
      coproc && wrFall ##[1:1000] (wrRise && fifoInReady);
   endsequence
   chk_flag_clear: assert property (p0Wr && ioWrData[1] && !ev[1] |=> !q.cr[1])
      else $error("flag not cleared by one write");
   chk_irq_hold: assert property ((q.cr[3:0] & q.cr[7:4]) != 4'h0 |=> cpuIrq)
      else $error("enabled flag without request");
   chk_irq_mask: assert property ((q.cr[3:0] & q.cr[7:4]) == 4'h0 |=> !cpuIrq)
      else $error("request without enabled flag");
   chk_xf_follow: assert property (p0Wr |=> externalFlagOutput == $past(ioWrData[10]))
      else $error("flag pin not from written bit");
   chk_hi_write: assert property (p1Wr && q.cr[8] |=> q.cr[23:16] == $past(ioWrData[7:0]))
      else $error("upper half not written");
   chk_pulse_width: assert property (pulseTicks <= (q.cr[28] ? 4'h8 : 4'h1))
      else $error("frame pulse too wide");
   chk_host_write: assert property (sHostWrite |=> q.cr[0] ##1 cpuIrq || !q.cr[4])
      else $error("host write raised no interrupt");
   chk_rd_edges: assert property (rdFall && !p5Wr |=> !transmitLatchFullFlag)
      else $error("full flag not cleared");
   chk_rd_done: assert property (rdRise |=> transferDonePollInput)
      else $error("done not signalled");
endmodule

// File: dsc_host_model.sv
// Behavioural model of the external host on the latch pins
module dsc_host_model
(
   input  wire logic        clk,
   output logic             hostWrN,
   output logic             hostRdN,
   output logic             latchByteSelect,
   output logic [15:0]      hostDataIn,
   input  wire logic [15:0] hostDataOut,
   input  wire logic        hostDataOe
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle: strobes high, lines released
   initial
   begin
      hostWrN = 1'b1;
      hostRdN = 1'b1;
      latchByteSelect = 1'b0;
      hostDataIn = 16'hA5A5;
   end
   // Strobe low, then data, then rising edge latches it
   task automatic writeWord(input logic sel, input logic [15:0] d);
      hostWrN = 1'b0;
      latchByteSelect = sel;
      repeat (2) @(posedge clk);
      #1 hostDataIn = d;
      repeat (8) @(posedge clk);
      #1 hostWrN = 1'b1;
      repeat (8) @(posedge clk);
      // Released lines show the inverse, not the old word
      #1 hostDataIn = ~d;
   endtask
   // Read strobe held low while the latch drives
   task automatic readWord(input logic sel, output logic [15:0] d);
      hostRdN = 1'b0;
      latchByteSelect = sel;
      repeat (8) @(posedge clk);
      #1 d = hostDataOe ? hostDataOut : 16'hDEAD;
      hostRdN = 1'b1;
      repeat (8) @(posedge clk);
      #1;
   endtask
endmodule

// File: test_dsp_system_control_and_host_latch.sv
// Self-checking bench for the control word and host latch
module test_dsp_system_control_and_host_latch;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk;
   logic        nrst;
   logic [2:0]  ioAddr;
   logic        ioWrStb;
   logic        ioRdStb;
   logic [15:0] ioWrData;
   logic [15:0] ioRdData;
   logic        cpuIrq;
   logic        modePin;
   logic        mcPin;
   logic        hostWrN;
   logic        hostRdN;
   logic        byteSel;
   logic [15:0] hostDataIn;
   logic [15:0] hostDataOut;
   logic        hostDataOe;
   logic        hostWrReady;
   logic        emptyFlag;
   logic        fullFlag;
   logic        doneFlag;
   logic        exIntPin;
   logic        rxSync;
   logic        txSync;
   logic        sclkIn;
   logic        sclkOe;
   logic        serEn;
   logic        encEn;
   logic        decEn;
   logic        aLaw;
   logic        twos;
   logic        xfOut;
   logic [15:0] compRd;
   logic        sclkOut;
   logic        frPulse;
   logic        txStart;
   logic        rxStart;
   logic        compWr;
   logic [15:0] compData;
   int          rxSeen = 0;
   int          compSeen = 0;
   int          failCount = 0;
   int          checked = 0;
   int          cycles = 0;
   logic [15:0] d;
   dsc_sys_ctrl dut (.core_clk(core_clk), .nrst(nrst), .ioAddr(ioAddr), .ioWrStb(ioWrStb),
      .ioRdStb(ioRdStb), .ioWrData(ioWrData), .ioRdData(ioRdData), .cpuIrq(cpuIrq),
      .coprocessorModeSelect(modePin), .microcomputerSelectPin(mcPin), .hostWrN(hostWrN),
      .hostRdN(hostRdN), .latchByteSelect(byteSel), .hostDataIn(hostDataIn),
      .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .hostWrReady(hostWrReady),
      .receiveLatchEmptyFlag(emptyFlag), .transmitLatchFullFlag(fullFlag),
      .transferDonePollInput(doneFlag), .externalInterruptPin(exIntPin),
      .receiveFrameSyncIn(rxSync), .transmitFrameSyncIn(txSync), .serialClockIn(sclkIn),
      .serialClockOut(sclkOut), .serialClockOe(sclkOe), .internalFramePulse(frPulse),
      .txFrameStart(txStart), .rxFrameStart(rxStart), .serialEnable(serEn),
      .encoderEnable(encEn), .decoderEnable(decEn),
      .aLawSelect(aLaw), .twosComplementSelect(twos), .externalFlagOutput(xfOut),
      .compWrStrobe(compWr), .compWrData(compData), .compRdData(compRd));
   dsc_host_model host (.clk(core_clk), .hostWrN(hostWrN), .hostRdN(hostRdN),
      .latchByteSelect(byteSel), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
      .hostDataOe(hostDataOe));
   // Free-running clock, 8 ns period
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // Hang guard: far above the fewer than a thousand cycles the tests need
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failCount++;
         closeOut();
      end
   end
   // One-cycle strobes tallied mid-cycle, where the outputs are settled
   always @(negedge core_clk)
   begin
      rxSeen += int'(rxStart);
      compSeen += int'(compWr);
   end
   task automatic closeOut;
      $display("Checks %0d mismatches %0d", checked, failCount);
      if (failCount == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic cmp16(input string what, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e)
      begin
         failCount++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic cmp1(input string what, input logic e, input logic g);
      checked++;
      if (g !== e)
      begin
         failCount++;
         $display("MISMATCH %s expected %b seen %b", what, e, g);
      end
   endtask
   task automatic waitCycles(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // One-cycle write strobe; a spare edge keeps strobes apart
   task automatic ioWrite(input logic [2:0] a, input logic [15:0] v);
      ioAddr = a;
      ioWrData = v;
      ioWrStb = 1'b1;
      waitCycles(1);
      ioWrStb = 1'b0;
      waitCycles(1);
   endtask
   // Answer lands on the edge that takes the strobe; it is sampled one edge later
   task automatic ioRead(input logic [2:0] a, output logic [15:0] v);
      ioAddr = a;
      ioRdStb = 1'b1;
      waitCycles(1);
      ioRdStb = 1'b0;
      waitCycles(1);
      v = ioRdData;
   endtask
   task automatic testCtrl;
      ioRead(3'h0, d);
      cmp16("port0 reset", 16'h0000, d);
      cmp1("twos reset", 1'b0, twos);
      ioRead(3'h2, d);
      cmp16("unmapped port", 16'h0000, d);
      ioWrite(3'h0, 16'hFD00);
      cmp1("flag pin", 1'b1, xfOut);
      cmp1("serial mode", 1'b1, serEn);
      cmp1("encoder", 1'b1, encEn);
      cmp1("decoder", 1'b1, decEn);
      cmp1("law", 1'b1, aLaw);
      cmp1("clock oe", 1'b0, sclkOe);
      ioWrite(3'h0, 16'h0300);
      cmp1("flag pin off", 1'b0, xfOut);
      cmp1("clock oe on", 1'b1, sclkOe);
      ioRead(3'h0, d);
      cmp16("port0 back", 16'h0300, d);
      ioWrite(3'h1, 16'h7FEF);
      ioRead(3'h1, d);
      cmp16("port1 readback", 16'h7FEF, d);
      cmp1("twos set", 1'b1, twos);
      ioWrite(3'h1, 16'h4010);
      ioRead(3'h1, d);
      cmp16("port1 wide", 16'h4010, d);
      $display("test control word done");
   endtask
   task automatic testFlags;
      ioWrite(3'h0, 16'h0100);
      host.writeWord(1'b0, 16'h1234);
      cmp1("empty cleared", 1'b0, emptyFlag);
      ioRead(3'h0, d);
      cmp16("masked flag", 16'h0101, d);
      cmp1("irq masked", 1'b0, cpuIrq);
      ioWrite(3'h0, 16'h0110);
      waitCycles(2);
      cmp1("irq enabled", 1'b1, cpuIrq);
      ioRead(3'h0, d);
      cmp16("zero keeps flag", 16'h0111, d);
      ioWrite(3'h0, 16'h0111);
      waitCycles(2);
      cmp1("irq cleared", 1'b0, cpuIrq);
      ioRead(3'h5, d);
      cmp16("latch word", 16'h1234, d);
      waitCycles(2);
      cmp1("empty set", 1'b1, emptyFlag);
      rxSync = 1'b1;
      waitCycles(6);
      rxSync = 1'b0;
      waitCycles(6);
      ioRead(3'h0, d);
      cmp1("rx sync flag", 1'b1, d[1]);
      ioWrite(3'h0, 16'h0112);
      ioRead(3'h0, d);
      cmp1("rx flag cleared", 1'b0, d[1]);
      $display("test flags done");
   endtask
   task automatic testFifo;
      for (int i = 0; i < 4; i++)
         host.writeWord(1'b0, 16'hA000 + 16'(i));
      cmp1("fifo full", 1'b0, hostWrReady);
      host.writeWord(1'b0, 16'h5555);
      for (int i = 0; i < 4; i++)
      begin
         ioRead(3'h5, d);
         cmp16("fifo order", 16'hA000 + 16'(i), d);
         cmp1("empty level", i == 3, emptyFlag);
      end
      ioRead(3'h5, d);
      cmp16("empty latch", 16'h0000, d);
      waitCycles(2);
      cmp1("drained empty", 1'b1, emptyFlag);
      $display("test fifo done");
   endtask
   task automatic testHostRead;
      ioWrite(3'h5, 16'hBEEF);
      cmp1("full set", 1'b1, fullFlag);
      host.readWord(1'b0, d);
      cmp16("host word", 16'hBEEF, d);
      cmp1("full cleared", 1'b0, fullFlag);
      cmp1("done set", 1'b1, doneFlag);
      ioWrite(3'h1, 16'h0010);
      host.writeWord(1'b1, 16'h00AB);
      host.writeWord(1'b0, 16'h00CD);
      ioRead(3'h5, d);
      cmp16("byte pair", 16'hABCD, d);
      ioWrite(3'h5, 16'h1357);
      cmp1("done cleared", 1'b0, doneFlag);
      host.readWord(1'b1, d);
      cmp16("upper byte", 16'h0013, d);
      host.readWord(1'b0, d);
      cmp16("lower byte", 16'h0057, d);
      $display("test host read done");
   endtask
   // Cycles to the next rise of the frame pulse, tallying levels on the way
   task automatic frameWindow(output int n, output int hi, output int sc, output int ts);
      logic last;
      n = 0;
      hi = 0;
      sc = 0;
      ts = 0;
      do
      begin
         hi += int'(frPulse);
         sc += int'(sclkOut);
         ts += int'(txStart);
         last = frPulse;
         waitCycles(1);
         n++;
      end
      while (!(frPulse && !last) && n < 1000);
   endtask
   // Divider 10, modulus 8: a frame every 100 cycles; then codec port and mode pins
   task automatic testFrame;
      int n, hi, sc, ts;
      ioWrite(3'h1, 16'h0C08);
      frameWindow(n, hi, sc, ts);
      frameWindow(n, hi, sc, ts);
      cmp16("frame period", 16'h0064, 16'(n));
      cmp16("narrow pulse", 16'h000A, 16'(hi));
      cmp16("bit clock high", 16'h0032, 16'(sc));
      cmp16("internal starts", 16'h0001, 16'(ts));
      ioWrite(3'h0, 16'h0310);
      ioWrite(3'h1, 16'h1C08);
      frameWindow(n, hi, sc, ts);
      frameWindow(n, hi, sc, ts);
      cmp16("wide pulse", 16'h0050, 16'(hi));
      cmp16("external tx starts", 16'h0000, 16'(ts));
      n = rxSeen;
      rxSync = 1'b1;
      waitCycles(6);
      rxSync = 1'b0;
      waitCycles(6);
      cmp16("external rx starts", 16'h0001, 16'(rxSeen - n));
      ioWrite(3'h0, 16'h0000);
      n = compSeen;
      ioWrite(3'h1, 16'h00AA);
      cmp16("codec strobes", 16'h0001, 16'(compSeen - n));
      cmp16("codec data", 16'h00AA, compData);
      compRd = 16'h3C3C;
      ioRead(3'h1, d);
      cmp16("codec read", 16'h3C3C, d);
      modePin = 1'b1;
      mcPin = 1'b1;
      waitCycles(6);
      ioWrite(3'h5, 16'h2468);
      cmp1("generic port5", 1'b0, fullFlag);
      $display("test frame and modes done");
   endtask
   // Reset held 5 cycles, then the tests in turn
   initial
   begin
      nrst = 1'b0;
      ioAddr = 3'h0;
      ioWrStb = 1'b0;
      ioRdStb = 1'b0;
      ioWrData = 16'h0000;
      modePin = 1'b0;
      mcPin = 1'b0;
      exIntPin = 1'b0;
      rxSync = 1'b0;
      txSync = 1'b0;
      sclkIn = 1'b0;
      compRd = 16'h0000;
      waitCycles(5);
      nrst = 1'b1;
      waitCycles(4);
      testCtrl();
      testFlags();
      testFifo();
      testHostRead();
      testFrame();
      closeOut();
   end
endmodule
